// *** design/ismb_top.sv ***
`include "ismb_consts.svh"

// How it works
// - range field bits 7..1 is upper bound
// - nonzero write with match enable arms range
// - range bit 0 reads zero
// - both lines high too long sets free flag
// - bus counts free only after high timeout
// - fast ack picks byte ack timing
// - bit 6 enables alert address match
// - bit 5 enables second address match
// - bit 4 picks clock or clock/64
// - low timeout flag, write one clears
// - zero limit disables low timeout
// - scl high sda low sets flag
// - bit 0 enables high-low interrupt
// - limit from two byte registers
// - second address register holds address
module ismb_top import ismb_pkg::*; (
   input wire logic aclk, // module clock
   input wire logic aresetn, // sync reset, low
   input wire logic [31:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte strobes
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [31:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic scl_in, // scl pin level
   input wire logic sda_in, // sda pin level
   input wire logic [6:0] rx_addr, // received address
   input wire logic rx_addr_valid, // address pulse
   input wire logic byte_rcvd, // data byte received
   output logic addr_match, // address hit
   output logic match_valid, // hit result pulse
   output logic ack_valid, // ack decision pulse
   output logic ack_nack, // 1 nack, 0 ack
   output logic irq // interrupt level
);
   // register index from a byte address, all ones if above 0xFF or unaligned
   function automatic logic [5:0] reg_idx(input logic [31:0] a);
      if (a[31:8] != 24'h000000 || a[1:0] != 2'h0) begin
         return 6'h3F;
      end
      return a[7:2];
   endfunction

   // decoded readable index
   function automatic logic known(input logic [5:0] i);
      return (i >= `ISMB_IDX_RANGE) && (i <= `ISMB_IDX_IRQ_EN);
   endfunction

   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff; // bus flops
   logic [1:0] bresp_ff, rresp_ff; // responses
   logic [31:0] rdata_ff; // read data
   logic aw_hold_ff, w_hold_ff; // captured halves
   logic [5:0] aw_idx_ff; // captured write index
   logic [7:0] wbyte_ff; // captured low byte
   logic wstrb0_ff; // low lane strobe
   logic [6:0] rad_ff; // range bound
   logic range_valid_ff; // range armed
   ismb_smb_t smb_ff; // smbus fields
   logic [6:0] sad_ff; // second address
   logic [15:0] lim_ff; // low timeout limit
   logic [6:0] own_ff; // primary address
   logic range_match_enable_ff; // range match enable
   logic transmit_ack_control_ff; // ack control
   logic [2:0] istat_ff, ien_ff; // interrupt regs
   logic [2:0] scl_s_ff, sda_s_ff; // pin synchronisers
   ismb_bus_t bus_ff; // filtered levels
   logic [5:0] presc_ff; // timeout prescaler
   logic [15:0] low_cnt_ff, hi_cnt_ff; // timeout counters
   logic [1:0] hi_st_ff; // bus levels of the last cycle
   logic low_to_q_ff, hilo_to_q_ff, free_q_ff; // edge memory
   logic addr_match_ff, match_valid_ff; // match outputs
   ismb_ack_st_t ack_st_ff; // ack state
   logic ack_valid_ff, ack_nack_ff, irq_ff; // outputs

   logic wr_go, wr_ok; // write commit
   logic tick; // timeout clock tick
   logic low_to, hi_to, free_to, hilo_to; // timeout conditions
   logic low_ev, hilo_ev, free_ev; // timeout events
   logic [7:0] wb; // committed byte

   assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign wr_ok = wr_go && wstrb0_ff && known(aw_idx_ff);
   assign wb = wbyte_ff;

   // write channel, address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         aw_idx_ff <= 6'h00;
         wbyte_ff <= 8'h00;
         wstrb0_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `ISMB_RESP_OKAY;
      end else begin
         if (awvalid && awready_ff) begin
            aw_hold_ff <= 1'b1;
            aw_idx_ff <= reg_idx(awaddr);
            awready_ff <= 1'b0;
         end
         if (wvalid && wready_ff) begin
            w_hold_ff <= 1'b1;
            wbyte_ff <= wdata[7:0];
            wstrb0_ff <= wstrb[0];
            wready_ff <= 1'b0;
         end
         if (wr_go) begin
            // off-map writes are refused with slverr
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= known(aw_idx_ff) ? `ISMB_RESP_OKAY : `ISMB_RESP_SLVERR;
         end
         if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
      end
   end

   // read channel, data registered one edge after address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= `ISMB_RESP_OKAY;
      end else if (arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rresp_ff <= known(reg_idx(araddr)) ? `ISMB_RESP_OKAY : `ISMB_RESP_SLVERR;
         case (reg_idx(araddr))
            `ISMB_IDX_RANGE: rdata_ff <= {24'h000000, rad_ff, 1'b0};
            `ISMB_IDX_SMB: rdata_ff <= {24'h000000, smb_ff};
            `ISMB_IDX_ADDR2: rdata_ff <= {24'h000000, sad_ff, 1'b0};
            `ISMB_IDX_LIM_HI: rdata_ff <= {24'h000000, lim_ff[15:8]};
            `ISMB_IDX_LIM_LO: rdata_ff <= {24'h000000, lim_ff[7:0]};
            `ISMB_IDX_CTRL: rdata_ff <= {24'h000000, own_ff, range_match_enable_ff};
            `ISMB_IDX_ACK: rdata_ff <= {30'h00000000, ack_st_ff == ISMB_ACK_WAIT, transmit_ack_control_ff};
            `ISMB_IDX_IRQ_STAT: rdata_ff <= {29'h00000000, istat_ff};
            `ISMB_IDX_IRQ_EN: rdata_ff <= {29'h00000000, ien_ff};
            // clear register is write only, off map reads zero
            default: rdata_ff <= 32'h00000000;
         endcase
      end else if (rvalid_ff && rready) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // plain software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rad_ff <= 7'h00;
         range_valid_ff <= 1'b0;
         sad_ff <= 7'h00;
         lim_ff <= 16'h0000;
         own_ff <= 7'h00;
         range_match_enable_ff <= 1'b0;
         transmit_ack_control_ff <= 1'b0;
         ien_ff <= `ISMB_RST_IRQ;
      end else if (wr_ok) begin
         case (aw_idx_ff)
            `ISMB_IDX_RANGE: begin
               rad_ff <= wb[7:1];
               range_valid_ff <= range_match_enable_ff && (wb != 8'h00);
            end
            `ISMB_IDX_ADDR2: sad_ff <= wb[7:1];
            `ISMB_IDX_LIM_HI: lim_ff[15:8] <= wb;
            `ISMB_IDX_LIM_LO: lim_ff[7:0] <= wb;
            `ISMB_IDX_CTRL: begin
               own_ff <= wb[7:1];
               range_match_enable_ff <= wb[0];
            end
            `ISMB_IDX_ACK: transmit_ack_control_ff <= wb[0];
            `ISMB_IDX_IRQ_EN: ien_ff <= wb[2:0];
            default: ;
         endcase
      end
   end

   // smbus register: set of a flag wins over its clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         smb_ff <= ismb_smb_t'(`ISMB_RST_BYTE);
      end else begin
         if (wr_ok && aw_idx_ff == `ISMB_IDX_SMB) begin
            smb_ff.fast_ack_enable <= wb[`ISMB_B_FAST_ACK_ENABLE];
            smb_ff.alert_en <= wb[`ISMB_B_ALERT];
            smb_ff.sec_en <= wb[`ISMB_B_SEC];
            smb_ff.timeout_clock_select <= wb[`ISMB_B_TCK];
            smb_ff.high_low_timeout_irq_enable <= wb[`ISMB_B_HIGH_LOW_TIMEOUT_IRQ_ENABLE];
            if (wb[`ISMB_B_SCL_LOW_TIMEOUT_FLAG]) begin
               smb_ff.scl_low_timeout_flag <= 1'b0;
            end
            if (wb[`ISMB_B_SCL_HIGH_SDA_LOW_TIMEOUT_FLAG]) begin
               smb_ff.scl_high_sda_low_timeout_flag <= 1'b0;
            end
         end
         if (low_ev) begin
            smb_ff.scl_low_timeout_flag <= 1'b1;
         end
         if (hilo_ev) begin
            smb_ff.scl_high_sda_low_timeout_flag <= 1'b1;
         end
         // read only, follows the free state
         smb_ff.bus_free_high_timeout_flag <= free_to;
      end
   end

   // three flop synchronisers; a level counts once flops 2 and 3 agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_s_ff <= 3'h7;
         sda_s_ff <= 3'h7;
         bus_ff <= 2'h3;
      end else begin
         scl_s_ff <= {scl_s_ff[1:0], scl_in};
         sda_s_ff <= {sda_s_ff[1:0], sda_in};
         if (scl_s_ff[1] == scl_s_ff[2]) begin
            bus_ff.scl <= scl_s_ff[2];
         end
         if (sda_s_ff[1] == sda_s_ff[2]) begin
            bus_ff.sda <= sda_s_ff[2];
         end
      end
   end

   // tick every clock or every 64th
   assign tick = smb_ff.timeout_clock_select || (presc_ff == `ISMB_PRESC_LAST);

   // free running prescaler, wraps at 64
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc_ff <= 6'h00;
      end else begin
         presc_ff <= presc_ff + 6'h01;
      end
   end

   assign low_to = (lim_ff != 16'h0000) && !bus_ff.scl && (low_cnt_ff > lim_ff);
   // below the limit the bus is not yet free
   // a line change voids the stale count, else a flag would fire at once
   assign hi_to = (hi_st_ff == bus_ff) && (hi_cnt_ff > {9'h000, lim_ff[15:`ISMB_HI_SHIFT]});
   assign free_to = bus_ff.scl && bus_ff.sda && hi_to;
   assign hilo_to = bus_ff.scl && !bus_ff.sda && hi_to;
   assign low_ev = low_to && !low_to_q_ff;
   assign hilo_ev = hilo_to && !hilo_to_q_ff;
   assign free_ev = free_to && !free_q_ff;

   // low counter, restarts while scl high, saturates
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_cnt_ff <= 16'h0000;
      end else if (bus_ff.scl || lim_ff == 16'h0000) begin
         low_cnt_ff <= 16'h0000;
      end else if (tick && low_cnt_ff != 16'hFFFF) begin
         low_cnt_ff <= low_cnt_ff + 16'h0001;
      end
   end

   // high phase counter restarts on any line change
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hi_cnt_ff <= 16'h0000;
         hi_st_ff <= 2'h0;
      end else begin
         hi_st_ff <= bus_ff;
         if (!bus_ff.scl || hi_st_ff != bus_ff) begin
            hi_cnt_ff <= 16'h0000;
         end else if (tick && hi_cnt_ff != 16'hFFFF) begin
            hi_cnt_ff <= hi_cnt_ff + 16'h0001;
         end
      end
   end

   // edge memory so a lasting timeout fires once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_to_q_ff <= 1'b0;
         hilo_to_q_ff <= 1'b0;
         free_q_ff <= 1'b0;
      end else begin
         low_to_q_ff <= low_to;
         hilo_to_q_ff <= hilo_to;
         free_q_ff <= free_to;
      end
   end

   // sticky status, set beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         istat_ff <= `ISMB_RST_IRQ;
      end else begin
         istat_ff <= (istat_ff & ~((wr_ok && aw_idx_ff == `ISMB_IDX_IRQ_CLR) ? wb[2:0] : 3'h0))
            | {free_ev, hilo_ev, low_ev};
      end
   end

   // flag bit gated by its own enable too
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (|(istat_ff & ien_ff)) || (smb_ff.scl_high_sda_low_timeout_flag && smb_ff.high_low_timeout_irq_enable);
      end
   end

   // address match, one edge after the address pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_match_ff <= 1'b0;
         match_valid_ff <= 1'b0;
      end else begin
         match_valid_ff <= rx_addr_valid;
         if (rx_addr_valid) begin
            addr_match_ff <= (rx_addr == own_ff)
               || (range_match_enable_ff && range_valid_ff && rx_addr >= own_ff && rx_addr <= rad_ff)
               || (smb_ff.sec_en && rx_addr == sad_ff)
               || (smb_ff.alert_en && rx_addr == `ISMB_ALERT_ADDR);
         end
      end
   end

   // ack now, or wait for software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ack_st_ff <= ISMB_ACK_IDLE;
         ack_valid_ff <= 1'b0;
         ack_nack_ff <= 1'b0;
      end else begin
         ack_valid_ff <= 1'b0;
         case (ack_st_ff)
            ISMB_ACK_IDLE: begin
               if (byte_rcvd && !smb_ff.fast_ack_enable) begin
                  ack_valid_ff <= 1'b1;
                  ack_nack_ff <= transmit_ack_control_ff;
               end else if (byte_rcvd) begin
                  ack_st_ff <= ISMB_ACK_WAIT;
               end
            end
            ISMB_ACK_WAIT: begin
               // software decides this byte's answer
               if (wr_ok && aw_idx_ff == `ISMB_IDX_ACK) begin
                  ack_valid_ff <= 1'b1;
                  ack_nack_ff <= wb[0];
                  ack_st_ff <= ISMB_ACK_IDLE;
               end
            end
            default: ack_st_ff <= ISMB_ACK_IDLE;
         endcase
      end
   end

   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign addr_match = addr_match_ff;
   assign match_valid = match_valid_ff;
   assign ack_valid = ack_valid_ff;
   assign ack_nack = ack_nack_ff;
   assign irq = irq_ff;

   // helper: index of the read in flight
   logic [5:0] rd_idx_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_idx_ff <= 6'h00;
      end else if (arvalid && arready_ff) begin
         rd_idx_ff <= reg_idx(araddr);
      end
   end

   property p_rsv_zero;
      @(posedge aclk) disable iff (!aresetn)
      rvalid_ff && rd_idx_ff == `ISMB_IDX_RANGE |-> rdata_ff[0] == 1'b0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("range bit 0 not zero");

   property p_range_arm;
      @(posedge aclk) disable iff (!aresetn)
      wr_ok && aw_idx_ff == `ISMB_IDX_RANGE && range_match_enable_ff && wb != 8'h00 |=> range_valid_ff;
   endproperty
   a_range_arm: assert property (p_range_arm) else $error("range not armed");

   property p_free_flag;
      @(posedge aclk) disable iff (!aresetn)
      smb_ff.bus_free_high_timeout_flag |-> $past(bus_ff.scl) && $past(bus_ff.sda);
   endproperty
   a_free_flag: assert property (p_free_flag) else $error("free flag without idle bus");

   property p_fast_off_ack;
      @(posedge aclk) disable iff (!aresetn)
      byte_rcvd && !smb_ff.fast_ack_enable && ack_st_ff == ISMB_ACK_IDLE |=> ack_valid_ff && ack_nack_ff == $past(transmit_ack_control_ff);
   endproperty
   a_fast_off_ack: assert property (p_fast_off_ack) else $error("ack not sent on byte");

   property p_alert;
      @(posedge aclk) disable iff (!aresetn)
      rx_addr_valid && smb_ff.alert_en && rx_addr == `ISMB_ALERT_ADDR |=> addr_match_ff;
   endproperty
   a_alert: assert property (p_alert) else $error("alert address missed");

   property p_slow_tick;
      @(posedge aclk) disable iff (!aresetn)
      tick && !smb_ff.timeout_clock_select ##1 !smb_ff.timeout_clock_select |-> (smb_ff.timeout_clock_select || !tick) [*8];
   endproperty
   a_slow_tick: assert property (p_slow_tick) else $error("slow tick too soon");

   property p_zero_limit;
      @(posedge aclk) disable iff (!aresetn)
      lim_ff == 16'h0000 |=> !$rose(smb_ff.scl_low_timeout_flag);
   endproperty
   a_zero_limit: assert property (p_zero_limit) else $error("low timeout with zero limit");

   property p_hilo_irq;
      @(posedge aclk) disable iff (!aresetn)
      smb_ff.scl_high_sda_low_timeout_flag && smb_ff.high_low_timeout_irq_enable |=> irq_ff;
   endproperty
   a_hilo_irq: assert property (p_hilo_irq) else $error("high-low irq missing");

   c_low_to: cover property (@(posedge aclk) disable iff (!aresetn) $rose(smb_ff.scl_low_timeout_flag));
   c_free: cover property (@(posedge aclk) disable iff (!aresetn) $rose(smb_ff.bus_free_high_timeout_flag));
   c_fast_ack: cover property (@(posedge aclk) disable iff (!aresetn)
      ack_st_ff == ISMB_ACK_WAIT ##[1:50] ack_valid_ff);
endmodule

// *** design/ismb_consts.svh ***
`ifndef ISMB_CONSTS_SVH
`define ISMB_CONSTS_SVH
// register indices, byte address is four times the index
`define ISMB_IDX_RANGE 6'h07
`define ISMB_IDX_SMB 6'h08
`define ISMB_IDX_ADDR2 6'h09
`define ISMB_IDX_LIM_HI 6'h0A
`define ISMB_IDX_LIM_LO 6'h0B
`define ISMB_IDX_CTRL 6'h0C
`define ISMB_IDX_ACK 6'h0D
`define ISMB_IDX_IRQ_STAT 6'h0E
`define ISMB_IDX_IRQ_CLR 6'h0F
`define ISMB_IDX_IRQ_EN 6'h10
// smbus register bit positions
`define ISMB_B_FAST_ACK_ENABLE 7
`define ISMB_B_ALERT 6
`define ISMB_B_SEC 5
`define ISMB_B_TCK 4
`define ISMB_B_SCL_LOW_TIMEOUT_FLAG 3
`define ISMB_B_BUS_FREE_HIGH_TIMEOUT_FLAG 2
`define ISMB_B_SCL_HIGH_SDA_LOW_TIMEOUT_FLAG 1
`define ISMB_B_HIGH_LOW_TIMEOUT_IRQ_ENABLE 0
// interrupt status bit positions
`define ISMB_I_LOW 0
`define ISMB_I_HILO 1
`define ISMB_I_FREE 2
// reset values
`define ISMB_RST_BYTE 8'h00
`define ISMB_RST_IRQ 3'h0
// timeout clock prescaler, 64 module clocks
`define ISMB_PRESC_DIV 64
`define ISMB_PRESC_LAST 6'h3F
// high timeout limit is the low limit divided by 512
`define ISMB_HI_SHIFT 9
// smbus alert response address
`define ISMB_ALERT_ADDR 7'h0C
// axi responses
`define ISMB_RESP_OKAY 2'h0
`define ISMB_RESP_SLVERR 2'h2
`endif

// *** design/ismb_pkg.sv ***
package ismb_pkg;
   // acknowledge decision sequencing
   typedef enum logic [1:0] {
      ISMB_ACK_IDLE = 2'b01,
      ISMB_ACK_WAIT = 2'b10
   } ismb_ack_st_t;
   // smbus control and status fields
   typedef struct packed {
      logic fast_ack_enable;
      logic alert_en;
      logic sec_en;
      logic timeout_clock_select;
      logic scl_low_timeout_flag;
      logic bus_free_high_timeout_flag;
      logic scl_high_sda_low_timeout_flag;
      logic high_low_timeout_irq_enable;
   } ismb_smb_t;
   // synchronised bus levels
   typedef struct packed {
      logic scl;
      logic sda;
   } ismb_bus_t;
endpackage

// *** dv/ismb_bus_model.sv ***
// other bus parties: open-drain lines with pull-ups
module ismb_bus_model (
   input wire logic scl_hold, // pull scl low
   input wire logic sda_hold, // pull sda low
   output logic scl, // wired scl level
   output logic sda // wired sda level
);
   timeunit 1ns;
   timeprecision 100ps;
   // released lines float back high through the pull-up
   assign scl = !scl_hold;
   assign sda = !sda_hold;
endmodule

// *** dv/ismb_top_tb.sv ***
`include "ismb_consts.svh"
module ismb_top_tb import ismb_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 1'h0, aresetn = 1'h0; // clock, reset
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0; // bus payloads
   logic [3:0] wstrb = 4'h0; // strobes
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0; // handshakes
   logic awready, wready, bvalid, arready, rvalid, addr_match, match_valid, ack_valid, ack_nack, irq;
   logic [1:0] bresp, rresp; // responses
   logic [31:0] rdata, rd_d; // read data, captured
   logic [1:0] rd_r; // captured response
   logic [6:0] rx_addr = 7'h0; // received address
   logic rx_addr_valid = 1'h0, byte_rcvd = 1'h0, scl_hold = 1'h0, sda_hold = 1'h0, scl_in, sda_in;
   logic last_hit, last_nack; // last pulse payloads
   int num_errors = 0, comparisons = 0, n_match = 0, n_ack = 0;
   always #2.5 aclk = !aclk;
   ismb_bus_model i_bus (.scl_hold(scl_hold), .sda_hold(sda_hold), .scl(scl_in), .sda(sda_in));
   ismb_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .scl_in(scl_in), .sda_in(sda_in), .rx_addr(rx_addr),
      .rx_addr_valid(rx_addr_valid), .byte_rcvd(byte_rcvd), .addr_match(addr_match),
      .match_valid(match_valid), .ack_valid(ack_valid), .ack_nack(ack_nack), .irq(irq));
   // pulse watchers, so a pulse inside a bus cycle is never missed
   always @(posedge aclk) begin
      if (match_valid === 1'h1) begin
         n_match++;
         last_hit = addr_match;
      end
      if (ack_valid === 1'h1) begin
         n_ack++;
         last_nack = ack_nack;
      end
   end
   task check_eq(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      $display("%0d compares, %0d mismatches", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task hang;
      num_errors++;
      $display("unexpected at %0t: bus gave no answer", $time);
      complete_run();
   endtask
   // write: both channels offered together, each dropped once taken
   task wr(input logic [5:0] idx, input logic [7:0] d);
      awaddr <= {24'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         if (bvalid === 1'h1) begin
            rd_r = bresp;
            bready <= 1'h0;
            @(posedge aclk);
            return;
         end
      end
      hang();
   endtask
   task rd(input logic [5:0] idx);
      araddr <= {24'h0, idx, 2'h0};
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arready === 1'h1) arvalid <= 1'h0;
         if (rvalid === 1'h1) begin
            rd_d = rdata;
            rd_r = rresp;
            rready <= 1'h0;
            @(posedge aclk);
            return;
         end
      end
      hang();
   endtask
   task pulse_addr(input logic [6:0] a, input logic hit);
      int c;
      c = n_match;
      rx_addr <= a;
      rx_addr_valid <= 1'h1;
      @(posedge aclk);
      rx_addr_valid <= 1'h0;
      repeat (2) @(posedge aclk);
      check_eq(n_match - c, 1);
      check_eq(last_hit, hit);
   endtask
   // want is the count of ack decisions expected from one byte
   task pulse_byte(input int want, input logic nack);
      int c;
      c = n_ack;
      byte_rcvd <= 1'h1;
      @(posedge aclk);
      byte_rcvd <= 1'h0;
      repeat (4) @(posedge aclk);
      check_eq(n_ack - c, want);
      if (want > 0) check_eq(last_nack, nack);
   endtask
   task t_regs;
      for (int i = 7; i < 12; i++) begin
         rd(6'(i));
         check_eq(rd_d & 32'hFFFFFFFB, 32'h0);
      end
      rd(6'h3F);
      check_eq(rd_r, `ISMB_RESP_SLVERR);
      wr(6'h3F, 8'h11);
      check_eq(rd_r, `ISMB_RESP_SLVERR);
      $display("regs test ended");
   endtask
   task t_range;
      wr(`ISMB_IDX_CTRL, 8'h21);
      wr(`ISMB_IDX_RANGE, 8'h41);
      rd(`ISMB_IDX_RANGE);
      check_eq(rd_d, 32'h40);
      pulse_addr(7'h10, 1'h1);
      pulse_addr(7'h20, 1'h1);
      pulse_addr(7'h21, 1'h0);
      pulse_addr(7'h0F, 1'h0);
      wr(`ISMB_IDX_RANGE, 8'h00);
      pulse_addr(7'h18, 1'h0);
      // enable off during the write: range must stay unarmed
      wr(`ISMB_IDX_CTRL, 8'h20);
      wr(`ISMB_IDX_RANGE, 8'h41);
      wr(`ISMB_IDX_CTRL, 8'h21);
      pulse_addr(7'h18, 1'h0);
      $display("range test ended");
   endtask
   task t_alert;
      pulse_addr(`ISMB_ALERT_ADDR, 1'h0);
      wr(`ISMB_IDX_SMB, 8'h40);
      pulse_addr(`ISMB_ALERT_ADDR, 1'h1);
      wr(`ISMB_IDX_ADDR2, 8'h6A);
      rd(`ISMB_IDX_ADDR2);
      check_eq(rd_d, 32'h6A);
      pulse_addr(7'h35, 1'h0);
      wr(`ISMB_IDX_SMB, 8'h20);
      pulse_addr(7'h35, 1'h1);
      pulse_addr(`ISMB_ALERT_ADDR, 1'h0);
      $display("alert test ended");
   endtask
   task t_ack;
      int c;
      wr(`ISMB_IDX_SMB, 8'h00);
      wr(`ISMB_IDX_ACK, 8'h01);
      pulse_byte(1, 1'h1);
      wr(`ISMB_IDX_ACK, 8'h00);
      pulse_byte(1, 1'h0);
      wr(`ISMB_IDX_SMB, 8'h80);
      pulse_byte(0, 1'h0);
      rd(`ISMB_IDX_ACK);
      check_eq(rd_d[1], 1'h1);
      c = n_ack;
      // software answers the held byte late
      wr(`ISMB_IDX_ACK, 8'h01);
      repeat (2) @(posedge aclk);
      check_eq(n_ack - c, 1);
      check_eq(last_nack, 1'h1);
      wr(`ISMB_IDX_SMB, 8'h00);
      $display("ack test ended");
   endtask
   task t_low;
      wr(`ISMB_IDX_SMB, 8'h10);
      scl_hold <= 1'h1;
      repeat (40) @(posedge aclk);
      rd(`ISMB_IDX_SMB);
      check_eq(rd_d[3], 1'h0);
      wr(`ISMB_IDX_LIM_LO, 8'h03);
      repeat (20) @(posedge aclk);
      rd(`ISMB_IDX_SMB);
      check_eq(rd_d[3], 1'h1);
      rd(`ISMB_IDX_IRQ_STAT);
      check_eq(rd_d[0], 1'h1);
      check_eq(irq, 1'h0);
      wr(`ISMB_IDX_IRQ_EN, 8'h01);
      repeat (3) @(posedge aclk);
      check_eq(irq, 1'h1);
      scl_hold <= 1'h0;
      repeat (8) @(posedge aclk);
      wr(`ISMB_IDX_SMB, 8'h18);
      wr(`ISMB_IDX_IRQ_CLR, 8'h01);
      rd(`ISMB_IDX_SMB);
      check_eq(rd_d[3], 1'h0);
      check_eq(irq, 1'h0);
      // divided clock: one limit step is 64 module clocks
      wr(`ISMB_IDX_LIM_LO, 8'h01);
      wr(`ISMB_IDX_SMB, 8'h00);
      scl_hold <= 1'h1;
      repeat (30) @(posedge aclk);
      rd(`ISMB_IDX_SMB);
      check_eq(rd_d[3], 1'h0);
      repeat (300) @(posedge aclk);
      rd(`ISMB_IDX_SMB);
      check_eq(rd_d[3], 1'h1);
      scl_hold <= 1'h0;
      repeat (8) @(posedge aclk);
      wr(`ISMB_IDX_SMB, 8'h08);
      wr(`ISMB_IDX_IRQ_CLR, 8'h07);
      $display("low timeout test ended");
   endtask
   task t_high;
      wr(`ISMB_IDX_LIM_HI, 8'h04);
      wr(`ISMB_IDX_LIM_LO, 8'h00);
      wr(`ISMB_IDX_SMB, 8'h10);
      sda_hold <= 1'h1;
      repeat (30) @(posedge aclk);
      rd(`ISMB_IDX_SMB);
      check_eq(rd_d[2:1], 2'h1);
      check_eq(irq, 1'h0);
      wr(`ISMB_IDX_SMB, 8'h11);
      repeat (3) @(posedge aclk);
      check_eq(irq, 1'h1);
      sda_hold <= 1'h0;
      // look just after the synchronised change, before the limit runs out
      repeat (5) @(posedge aclk);
      rd(`ISMB_IDX_SMB);
      check_eq(rd_d[2], 1'h0);
      repeat (30) @(posedge aclk);
      rd(`ISMB_IDX_SMB);
      check_eq(rd_d[2], 1'h1);
      wr(`ISMB_IDX_SMB, 8'h13);
      repeat (3) @(posedge aclk);
      check_eq(irq, 1'h0);
      rd(`ISMB_IDX_IRQ_STAT);
      check_eq(rd_d[2:1], 2'h3);
      $display("high timeout test ended");
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_regs();
      t_range();
      t_alert();
      t_ack();
      t_low();
      t_high();
      complete_run();
   end
endmodule
